// ===== logic/fhrp_pkg.sv
/*
 * Shared constants, types and helper functions of the flash high range protection block.
 * Assumes an 8-bit register port and a 16-bit flash address space.
 */
package fhrp_pkg;

    localparam int FHRP_REG_AW = 8;
    localparam int FHRP_DATA_W = 8;
    localparam int FHRP_FLASH_AW = 16;
    localparam int FHRP_IRQ_W = 2;

    localparam logic [7:0] FHRP_PROT_OFS = 8'h04;
    localparam logic [7:0] FHRP_STAT_OFS = 8'h05;
    localparam logic [7:0] FHRP_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] FHRP_IRQ_CLR_OFS = 8'h09;
    localparam logic [7:0] FHRP_IRQ_EN_OFS = 8'h0a;

    localparam int FHRP_OPEN_BIT = 7;
    localparam int FHRP_SPARE_HI_BIT = 6;
    localparam int FHRP_HDIS_BIT = 5;
    localparam int FHRP_SIZE_MSB = 4;
    localparam int FHRP_SIZE_LSB = 3;
    localparam int FHRP_VIOL_BIT = 5;
    localparam int FHRP_EVT_VIOL = 0;
    localparam int FHRP_EVT_REJECT = 1;

    // Only the open select, disable and size bits are writable.
    localparam logic [7:0] FHRP_PROT_WR_MASK = 8'hb8;
    // Erased flash reads as all ones, so this is the unprotected setting.
    localparam logic [7:0] FHRP_PROT_RESET = 8'hff;
    localparam logic [15:0] FHRP_NV_PROT_ADDR = 16'hff0d;

    localparam logic [15:0] FHRP_BASE_2K = 16'hf800;
    localparam logic [15:0] FHRP_BASE_4K = 16'hf000;
    localparam logic [15:0] FHRP_BASE_8K = 16'he000;
    localparam logic [15:0] FHRP_BASE_16K = 16'hc000;

    typedef enum logic [1:0] {
        FHRP_CMD_PROGRAM,
        FHRP_CMD_SECTOR_ERASE,
        FHRP_CMD_MASS_ERASE,
        FHRP_CMD_OTHER
    } fhrp_cmd_t;

    typedef enum logic {
        FHRP_ST_LOAD,
        FHRP_ST_RUN
    } fhrp_state_t;

    typedef struct packed {
        fhrp_state_t st;
        logic [7:0] prot;
        logic viol;
        logic [7:0] rdata;
        logic launch;
        logic refuse;
    } fhrp_core_t;

    localparam fhrp_core_t FHRP_CORE_RESET = '{
        st: FHRP_ST_LOAD,
        prot: FHRP_PROT_RESET,
        viol: 1'b0,
        rdata: 8'h00,
        launch: 1'b0,
        refuse: 1'b0
    };

    // scenario number map.
    // Scenario number is {open select, high range disable}.
    function automatic logic [1:0] fhrp_scen(input logic [7:0] prot);
        return {prot[FHRP_OPEN_BIT], prot[FHRP_HDIS_BIT]};
    endfunction : fhrp_scen

    function automatic logic fhrp_trans_ok(input logic [1:0] from_s, input logic [1:0] to_s);
        logic ok;
        ok = 1'b0;
        unique case (from_s)
            2'd0: ok = (to_s == 2'd0) || (to_s == 2'd1);
            2'd1: ok = (to_s == 2'd1);
            2'd2: ok = (to_s == 2'd1) || (to_s == 2'd2);
            2'd3: ok = 1'b1;
        endcase
        return ok;
    endfunction : fhrp_trans_ok

    function automatic logic [15:0] fhrp_high_base(input logic [1:0] size);
        logic [15:0] base;
        base = FHRP_BASE_2K;
        unique case (size)
            2'b00: base = FHRP_BASE_2K;
            2'b01: base = FHRP_BASE_4K;
            2'b10: base = FHRP_BASE_8K;
            2'b11: base = FHRP_BASE_16K;
        endcase
        return base;
    endfunction : fhrp_high_base

endpackage : fhrp_pkg

// ===== logic/fhrp_range_check.sv
/*
 * Combinational check of one flash access against the protection setting.
 * Assumes the setting comes straight from the protection register.
 */
`timescale 1ns/10ps
`default_nettype none
module fhrp_range_check
    import fhrp_pkg::*;
#(
    parameter int AW = FHRP_FLASH_AW
) (
    input wire logic [7:0] prot_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic mass_i,
    output logic hit_o
);

    if (AW != 16) begin : g_bad_aw
        $error("Range decode serves a 16-bit flash address only.");
    end

    logic in_high;

    assign in_high = addr_i >= fhrp_high_base(prot_i[FHRP_SIZE_MSB:FHRP_SIZE_LSB]);

    always_comb begin
        hit_o = 1'b0;
        unique case (fhrp_scen(prot_i))
            2'd0: hit_o = !in_high;
            2'd1: hit_o = 1'b1;
            2'd2: hit_o = in_high;
            2'd3: hit_o = 1'b0;
        endcase
        if (mass_i) begin
            hit_o = (fhrp_scen(prot_i) != 2'd3);
        end
    end

endmodule : fhrp_range_check
`default_nettype wire

// ===== logic/fhrp_irq.sv
/*
 * Sticky event status, write-one clear and enable, folded into one level interrupt.
 * Assumes strobes from the register port of the main block.
 */
`timescale 1ns/10ps
`default_nettype none
module fhrp_irq #(
    parameter int W = 2
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] evt_i,
    input wire logic clr_wr_i,
    input wire logic en_wr_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] status_o,
    output logic [W-1:0] enable_o,
    output logic irq_o
);

    if (W < 1) begin : g_bad_w
        $error("Interrupt width must be at least one.");
    end

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] enable;
    } fhrp_irq_state_t;

    fhrp_irq_state_t irq_reg;
    fhrp_irq_state_t irq_next;

    always_comb begin
        irq_next = irq_reg;
        // An event in the clearing cycle survives, so none is lost.
        if (clr_wr_i) begin
            irq_next.status = irq_reg.status & ~wdata_i;
        end
        irq_next.status = irq_next.status | evt_i;
        if (en_wr_i) begin
            irq_next.enable = wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign status_o = irq_reg.status;
    assign enable_o = irq_reg.enable;
    assign irq_o = |(irq_reg.status & irq_reg.enable);

endmodule : fhrp_irq
`default_nettype wire

// ===== logic/fhrp_core.sv
/*
 * Flash high range protection: holds the protection register, loads it from the
 * nonvolatile byte after reset, limits software changes and screens flash commands.
 * Assumes a register master that never strobes read and write together, and a flash
 * reader that answers the load request with one acknowledge pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module fhrp_core
    import fhrp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [FHRP_REG_AW-1:0] reg_addr_i,
    input wire logic [FHRP_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [FHRP_DATA_W-1:0] reg_rdata_o,
    output logic nv_req_o,
    output logic [FHRP_FLASH_AW-1:0] nv_addr_o,
    input wire logic [FHRP_DATA_W-1:0] nv_data_i,
    input wire logic nv_ack_i,
    input wire logic cmd_valid_i,
    input wire fhrp_cmd_t cmd_kind_i,
    input wire logic [FHRP_FLASH_AW-1:0] cmd_addr_i,
    output logic cmd_launch_o,
    output logic cmd_refuse_o,
    output logic irq_o
);

    fhrp_core_t core_reg;
    fhrp_core_t core_next;

    logic in_run;
    logic prot_wr;
    logic stat_wr;
    logic [7:0] cand;
    logic size_ok;
    logic open_ok;
    logic wr_ok;
    logic checked;
    logic hit;
    logic [FHRP_IRQ_W-1:0] evt;
    logic [FHRP_IRQ_W-1:0] irq_status;
    logic [FHRP_IRQ_W-1:0] irq_enable;

    assign in_run = (core_reg.st == FHRP_ST_RUN);
    assign prot_wr = reg_wr_i && (reg_addr_i == FHRP_PROT_OFS);
    assign stat_wr = reg_wr_i && (reg_addr_i == FHRP_STAT_OFS);

    // Spare flag bits keep their loaded value; software cannot touch them.
    assign cand = (core_reg.prot & ~FHRP_PROT_WR_MASK) | (reg_wdata_i & FHRP_PROT_WR_MASK);

    assign open_ok = core_reg.prot[FHRP_OPEN_BIT] || !cand[FHRP_OPEN_BIT];

    assign size_ok = core_reg.prot[FHRP_HDIS_BIT]
        || (cand[FHRP_SIZE_MSB:FHRP_SIZE_LSB] == core_reg.prot[FHRP_SIZE_MSB:FHRP_SIZE_LSB]);

    assign wr_ok = open_ok && size_ok
        && fhrp_trans_ok(fhrp_scen(core_reg.prot), fhrp_scen(cand));

    // Only program and erase can alter the array, so other commands bypass the screen.
    assign checked = (cmd_kind_i != FHRP_CMD_OTHER);

    fhrp_range_check #(
        .AW(FHRP_FLASH_AW)
    ) u_range (
        .prot_i(core_reg.prot),
        .addr_i(cmd_addr_i),
        .mass_i(cmd_kind_i == FHRP_CMD_MASS_ERASE),
        .hit_o(hit)
    );

    always_comb begin
        core_next = core_reg;
        core_next.launch = 1'b0;
        core_next.refuse = 1'b0;
        core_next.rdata = 8'h00;
        evt = '0;

        unique case (core_reg.st)
            FHRP_ST_LOAD: begin
                if (nv_ack_i) begin
                    core_next.prot = nv_data_i;
                    core_next.st = FHRP_ST_RUN;
                end
                if (cmd_valid_i) begin
                    core_next.refuse = 1'b1;
                end
            end
            FHRP_ST_RUN: begin
                if (prot_wr) begin
                    if (wr_ok) begin
                        core_next.prot = cand;
                    end else begin
                        evt[FHRP_EVT_REJECT] = 1'b1;
                    end
                end
                if (stat_wr && reg_wdata_i[FHRP_VIOL_BIT]) begin
                    core_next.viol = 1'b0;
                end
                if (cmd_valid_i) begin
                    if (core_reg.viol) begin
                        core_next.refuse = 1'b1;
                    end else if (checked && hit) begin
                        core_next.refuse = 1'b1;
                        core_next.viol = 1'b1;
                        evt[FHRP_EVT_VIOL] = 1'b1;
                    end else begin
                        core_next.launch = 1'b1;
                    end
                end
            end
        endcase

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                FHRP_PROT_OFS: core_next.rdata = core_reg.prot;
                FHRP_STAT_OFS: core_next.rdata[FHRP_VIOL_BIT] = core_reg.viol;
                FHRP_IRQ_STAT_OFS: core_next.rdata[FHRP_IRQ_W-1:0] = irq_status;
                FHRP_IRQ_EN_OFS: core_next.rdata[FHRP_IRQ_W-1:0] = irq_enable;
                default: core_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            core_reg <= FHRP_CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    fhrp_irq #(
        .W(FHRP_IRQ_W)
    ) u_irq (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .evt_i(evt),
        .clr_wr_i(reg_wr_i && (reg_addr_i == FHRP_IRQ_CLR_OFS)),
        .en_wr_i(reg_wr_i && (reg_addr_i == FHRP_IRQ_EN_OFS)),
        .wdata_i(reg_wdata_i[FHRP_IRQ_W-1:0]),
        .status_o(irq_status),
        .enable_o(irq_enable),
        .irq_o(irq_o)
    );

    assign reg_rdata_o = core_reg.rdata;
    assign nv_req_o = (core_reg.st == FHRP_ST_LOAD);
    assign nv_addr_o = FHRP_NV_PROT_ADDR;
    assign cmd_launch_o = core_reg.launch;
    assign cmd_refuse_o = core_reg.refuse;

    // Helper copies so that the checks below can look one cycle back.
    logic run_d;
    logic [7:0] prot_d;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            run_d <= 1'b0;
            prot_d <= FHRP_PROT_RESET;
        end else begin
            run_d <= in_run;
            prot_d <= core_reg.prot;
        end
    end

    open_one_way_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (run_d && in_run && !prot_d[FHRP_OPEN_BIT]) |-> !core_reg.prot[FHRP_OPEN_BIT]
    ) else $error("Open select went from zero to one.");

    size_frozen_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (run_d && in_run && !prot_d[FHRP_HDIS_BIT])
        |-> (core_reg.prot[FHRP_SIZE_MSB:FHRP_SIZE_LSB] == prot_d[FHRP_SIZE_MSB:FHRP_SIZE_LSB])
    ) else $error("Size field changed while frozen.");

    nv_load_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (!in_run && nv_ack_i) |=> (in_run && core_reg.prot == $past(nv_data_i))
    ) else $error("Protection byte was not loaded on acknowledge.");

    prot_read_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == FHRP_PROT_OFS) |=> (reg_rdata_o == $past(core_reg.prot))
    ) else $error("Protection read did not show the register.");

    prot_access_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (in_run && !core_reg.viol && cmd_valid_i && checked && hit)
        |=> (core_reg.viol && cmd_refuse_o && !cmd_launch_o)
    ) else $error("Protected access was not refused with a violation.");

    mass_erase_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (in_run && !core_reg.viol && cmd_valid_i && cmd_kind_i == FHRP_CMD_MASS_ERASE)
        |=> (cmd_launch_o == $past(core_reg.prot[FHRP_OPEN_BIT] && core_reg.prot[FHRP_HDIS_BIT]))
    ) else $error("Mass erase outcome does not match the protection bits.");

    bad_write_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (in_run && prot_wr && !wr_ok) |=> $stable(core_reg.prot)
    ) else $error("Refused protection write changed the register.");

    scen_move_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (run_d && in_run) |-> fhrp_trans_ok(fhrp_scen(prot_d), fhrp_scen(core_reg.prot))
    ) else $error("Protection moved to a forbidden scenario.");

    viol_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (core_reg.viol && !(stat_wr && reg_wdata_i[FHRP_VIOL_BIT])) |=> core_reg.viol
    ) else $error("Violation flag cleared without a one written.");

    viol_block_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (core_reg.viol && cmd_valid_i) |=> (cmd_refuse_o && !cmd_launch_o)
    ) else $error("Command launched while the violation flag was set.");

    next_cycle_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (in_run && prot_wr && wr_ok) |=> (core_reg.prot == $past(cand))
    ) else $error("Accepted write was not in force the next cycle.");

    load_refuse_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (!in_run && cmd_valid_i)
        |=> (cmd_refuse_o && !cmd_launch_o && !core_reg.viol)
    ) else $error("Command during load was not refused quietly.");

    one_answer_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        cmd_valid_i
        |=> (cmd_launch_o != cmd_refuse_o)
    ) else $error("Command did not get exactly one answer.");

    rdata_idle_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !reg_rd_i |=> (reg_rdata_o == 8'h00)
    ) else $error("Read data stood outside the read cycle.");

    viol_read_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == FHRP_STAT_OFS)
        |=> (reg_rdata_o[FHRP_VIOL_BIT] == $past(core_reg.viol))
    ) else $error("Status read did not show the violation flag.");

    spare_keep_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (run_d && in_run)
        |-> ((core_reg.prot & ~FHRP_PROT_WR_MASK) == (prot_d & ~FHRP_PROT_WR_MASK))
    ) else $error("Spare protection bits changed at run time.");

    full_array_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (in_run && !core_reg.viol && cmd_valid_i && checked
            && fhrp_scen(core_reg.prot) == 2'd1)
        |=> cmd_refuse_o
    ) else $error("Command launched into a fully protected array.");

    no_prot_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (in_run && !core_reg.viol && cmd_valid_i
            && fhrp_scen(core_reg.prot) == 2'd3)
        |=> cmd_launch_o
    ) else $error("Command refused with protection fully open.");

endmodule : fhrp_core
`default_nettype wire

// ===== sim/flash_high_range_protection_tb_top.sv
/*
 * Self-checking bench of the flash high range protection core.
 * Assumes the core alone, driven at its ports, with the bench as register master and flash.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_high_range_protection_tb_top
    import fhrp_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic nv_req_o;
    logic [15:0] nv_addr_o;
    logic [7:0] nv_data_i = 8'h00;
    logic nv_ack_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    fhrp_cmd_t cmd_kind_i = FHRP_CMD_OTHER;
    logic [15:0] cmd_addr_i = 16'h0000;
    logic cmd_launch_o;
    logic cmd_refuse_o;
    logic irq_o;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hf16f_2d9a;
    logic [7:0] prot_m;
    logic viol_m;
    logic loading_m;

    fhrp_core uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .nv_req_o(nv_req_o), .nv_addr_o(nv_addr_o),
        .nv_data_i(nv_data_i), .nv_ack_i(nv_ack_i), .cmd_valid_i(cmd_valid_i),
        .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i), .cmd_launch_o(cmd_launch_o),
        .cmd_refuse_o(cmd_refuse_o), .irq_o(irq_o));

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0000_0000);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] base_of(input logic [1:0] s);
        return (s == 2'b00) ? FHRP_BASE_2K : (s == 2'b01) ? FHRP_BASE_4K :
            (s == 2'b10) ? FHRP_BASE_8K : FHRP_BASE_16K;
    endfunction : base_of

    function automatic logic move_ok(input logic [1:0] f, input logic [1:0] t);
        return (f == 2'd3) || (f == 2'd0 && t <= 2'd1) || (t == 2'd1) ||
            (f == 2'd2 && t == 2'd2);
    endfunction : move_ok

    // Returns refuse, then whether a new violation is raised.
    function automatic logic [1:0] cmd_exp(input logic [1:0] k, input logic [15:0] a);
        logic [1:0] sc;
        logic hit;
        sc = {prot_m[7], prot_m[5]};
        if (loading_m || viol_m) return 2'b10;
        if (k == 2'd3) return 2'b00;
        if (k == 2'd2) hit = (sc != 2'd3);
        else hit = (sc == 2'd1) || (sc == 2'd2 && a >= base_of(prot_m[4:3])) ||
            (sc == 2'd0 && a < base_of(prot_m[4:3]));
        return {hit, hit};
    endfunction : cmd_exp

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o & mk, e & mk, "register read");
    endtask : rd_chk

    task automatic clear_viol();
        rd_chk(FHRP_STAT_OFS, 8'h20, 8'h20);
        wr(FHRP_STAT_OFS, 8'h00);
        cmd(2'd3, 16'h0000, 1'b0);
        rd_chk(FHRP_STAT_OFS, 8'h20, 8'h20);
        wr(FHRP_STAT_OFS, 8'h20);
        rd_chk(FHRP_STAT_OFS, 8'h00, 8'h20);
        viol_m = 1'b0;
    endtask : clear_viol

    // With chain set the command rides the cycle right after a write strobe.
    task automatic cmd(input logic [1:0] k, input logic [15:0] a, input bit chain);
        logic [1:0] e;
        if (!chain) @(posedge sys_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_kind_i <= fhrp_cmd_t'(k);
        cmd_addr_i <= a;
        e = cmd_exp(k, a);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b0;
        #1;
        chk({6'h00, cmd_launch_o, cmd_refuse_o}, {6'h00, !e[1], e[1]}, "command");
        if (e[0]) begin
            viol_m = 1'b1;
            clear_viol();
        end
    endtask : cmd

    task automatic rst_load(input logic [7:0] d);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        loading_m = 1'b1;
        viol_m = 1'b0;
        chk({7'h00, nv_req_o}, 8'h01, "load request");
        chk(nv_addr_o[15:8], FHRP_NV_PROT_ADDR[15:8], "load address high");
        chk(nv_addr_o[7:0], FHRP_NV_PROT_ADDR[7:0], "load address low");
        cmd(2'(rnd() % 4), 16'(rnd()), 1'b0);
        @(posedge sys_clk_i);
        nv_ack_i <= 1'b1;
        nv_data_i <= d;
        @(posedge sys_clk_i);
        nv_ack_i <= 1'b0;
        #1;
        chk({7'h00, nv_req_o}, 8'h00, "load done");
        prot_m = d;
        loading_m = 1'b0;
        rd_chk(FHRP_PROT_OFS, d, 8'hff);
    endtask : rst_load

    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("FAIL at %0t: run did not finish", $time);
            conclude();
        end
    end

    initial begin
        logic [7:0] w;
        logic [7:0] d;
        logic ok;
        for (int f = 0; f < 4; f++) begin
            for (int t = 0; t < 4; t++) begin
                for (int r = 0; r < 2; r++) begin
                    // Spare bits stay erased in the stored byte.
                    d = {f[1], 1'b1, f[0], 2'(rnd() % 4), 3'b111};
                    rst_load(d);
                    w = 8'(rnd());
                    w[7] = t[1];
                    w[5] = t[0];
                    if (r == 0) w[4:3] = d[4:3];
                    ok = move_ok(2'(f), 2'(t)) && (d[5] || w[4:3] == d[4:3]);
                    prot_m = ok ? ((d & 8'h47) | (w & 8'hb8)) : d;
                    wr(FHRP_PROT_OFS, w);
                    cmd(2'd0, base_of(prot_m[4:3]), 1'b1);
                    rd_chk(FHRP_PROT_OFS, prot_m, 8'hff);
                    rd_chk(FHRP_IRQ_STAT_OFS, ok ? 8'h00 : 8'h02, 8'h02);
                    for (int j = 0; j < 6; j++) begin
                        if (j == 0) cmd(2'(rnd() % 3), base_of(prot_m[4:3]) - 16'h0001, 1'b0);
                        else cmd(2'(rnd() % 4), 16'(rnd()), 1'b0);
                    end
                end
            end
        end
        rst_load(8'hdf);
        wr(FHRP_IRQ_EN_OFS, 8'h01);
        rd_chk(FHRP_IRQ_EN_OFS, 8'h01, 8'h03);
        cmd(2'd1, 16'hffff, 1'b0);
        #1;
        chk({7'h00, irq_o}, 8'h01, "interrupt raised");
        wr(FHRP_IRQ_EN_OFS, 8'h00);
        #1;
        chk({7'h00, irq_o}, 8'h00, "interrupt masked");
        wr(FHRP_IRQ_EN_OFS, 8'h01);
        #1;
        chk({7'h00, irq_o}, 8'h01, "interrupt unmasked");
        wr(FHRP_IRQ_CLR_OFS, 8'h01);
        #1;
        chk({7'h00, irq_o}, 8'h00, "interrupt cleared");
        rd_chk(FHRP_IRQ_STAT_OFS, 8'h00, 8'h01);
        rd_chk(8'h33, 8'h00, 8'hff);
        cmd(2'd2, 16'h0000, 1'b0);
        cmd(2'd0, FHRP_NV_PROT_ADDR, 1'b0);
        rst_load(8'hff);
        cmd(2'd1, FHRP_NV_PROT_ADDR, 1'b0);
        cmd(2'd0, FHRP_NV_PROT_ADDR, 1'b0);
        cmd(2'd2, 16'h0000, 1'b0);
        conclude();
    end
endmodule : flash_high_range_protection_tb_top
`default_nettype wire
